// >>> include/csram_consts.svh
/*
 Timing constants for the clearable static memory controller.
 Assumes a 200 MHz system clock; times are slowest-grade figures in ns.
*/
`ifndef CSRAM_CONSTS_SVH
`define CSRAM_CONSTS_SVH

`define CSRAM_CLK_NS 5
`define CSRAM_ADDR_W 13
`define CSRAM_DATA_W 8
`define CSRAM_CNT_W 8

`define CSRAM_ACCESS_NS 55
`define CSRAM_CLEAR_PULSE_MIN_NS 100
`define CSRAM_CLEAR_RELEASE_TO_STROBE_NS 10
`define CSRAM_STROBE_WIDTH_MIN_NS 50
`define CSRAM_STROBE_TO_FLOAT_NS 25
`define CSRAM_ADDRESS_VALID_TO_WRITE_END_NS 50
`define CSRAM_OUTPUT_FLOAT_NS 25
`define CSRAM_SYNC_STAGES 2

// Least time to whole cycles, rounded up
`define CSRAM_CYC(ns) (((ns) + `CSRAM_CLK_NS - 1) / `CSRAM_CLK_NS)
`define CSRAM_MAX(a, b) (((a) > (b)) ? (a) : (b))

`endif

// >>> include/csram_pkg.sv
/*
 Types for the clearable static memory controller.
 Assumes csram_consts.svh is on the include path.
*/
package csram_pkg;
   typedef enum logic [7:0] {
      CSRAM_IDLE = 8'h01,
      CSRAM_WSET = 8'h02,
      CSRAM_WSTB = 8'h04,
      CSRAM_WHLD = 8'h08,
      CSRAM_RACC = 8'h10,
      CSRAM_RFLT = 8'h20,
      CSRAM_CLR = 8'h40,
      CSRAM_CREL = 8'h80
   } csram_state_t;
endpackage

// >>> hdl/csram_timer.sv
/*
 Loadable down counter that times the strobe, read, float, clear and release phases.
 Assumes the loader holds its state until o_done.
*/
module csram_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Load
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_count,
   // Status
   output logic o_done
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         count <= '0;
      end else if (i_load) begin
         count <= i_count;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign o_done = (count == '0);
endmodule

// >>> hdl/csram_ctrl.sv
/*
 Host-side controller for an asynchronous 8K x 8 static memory with a
 bulk-clear pin. Runs one read, write or clear at a time from a simple
 request port. Assumes the memory pins are wired directly and the data
 bus wire is resolved outside from o_byte_bus_oe.
*/
// How it works
// - The controller keeps strobe or a select inactive whenever the address moves.
// - With output enable low the strobe must span float time plus address-valid time.
// - The controller holds clear low for at least the minimum clear pulse.
// - After clear rises the controller waits the release time before a strobe.
// - The controller never drives the bus while the memory drives it.
`include "csram_consts.svh"

module csram_ctrl
   import csram_pkg::*;
#(
   parameter int ADDR_W = `CSRAM_ADDR_W,
   parameter int DATA_W = `CSRAM_DATA_W,
   parameter int CNT_W = `CSRAM_CNT_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Request port
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic [DATA_W-1:0] i_req_data,
   input wire logic i_clear_req,
   input wire logic i_power_down,
   output logic o_req_ready,
   output logic o_rd_valid,
   output logic [DATA_W-1:0] o_rd_data,
   output logic o_busy,
   // Memory pins
   output logic [ADDR_W-1:0] o_word_address,
   output logic [DATA_W-1:0] o_byte_bus_out,
   output logic o_byte_bus_oe,
   input wire logic [DATA_W-1:0] i_byte_bus_in,
   output logic o_select_low_active_n,
   output logic o_select_high_power,
   output logic o_output_enable_n,
   output logic o_write_strobe_n,
   output logic o_clear_n
);
   import csram_pkg::*;

   // Phase lengths in cycles
   localparam int WR_CYC = `CSRAM_MAX(`CSRAM_CYC(`CSRAM_STROBE_WIDTH_MIN_NS),
      `CSRAM_CYC(`CSRAM_STROBE_TO_FLOAT_NS + `CSRAM_ADDRESS_VALID_TO_WRITE_END_NS));
   localparam int CLR_CYC = `CSRAM_MAX(`CSRAM_CYC(`CSRAM_CLEAR_PULSE_MIN_NS),
      `CSRAM_CYC(2 * `CSRAM_ACCESS_NS));
   localparam int REL_CYC = `CSRAM_CYC(`CSRAM_CLEAR_RELEASE_TO_STROBE_NS);
   localparam int RD_CYC = `CSRAM_CYC(`CSRAM_ACCESS_NS) + `CSRAM_SYNC_STAGES + 1;
   localparam int FLT_CYC = `CSRAM_CYC(`CSRAM_OUTPUT_FLOAT_NS);

   csram_state_t state;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_count;
   logic tmr_done;
   logic [DATA_W-1:0] bus_meta;
   logic [DATA_W-1:0] bus_sync;

   function automatic logic [CNT_W-1:0] phase_len(input int cycles);
      phase_len = CNT_W'(cycles - 1);
   endfunction

   csram_timer #(
      .WIDTH(CNT_W)
   ) u_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_load(tmr_load),
      .i_count(tmr_count),
      .o_done(tmr_done)
   );

   assign o_req_ready = (state == CSRAM_IDLE) && !i_clear_req;
   assign o_busy = (state != CSRAM_IDLE);

   // Bus input crosses from the pins
   always_ff @(posedge i_clk) begin
      bus_meta <= i_byte_bus_in;
      bus_sync <= bus_meta;
   end

   always_comb begin
      tmr_load = 1'b0;
      tmr_count = '0;
      unique case (state)
         CSRAM_IDLE: begin
            if (i_clear_req) begin
               tmr_load = 1'b1;
               tmr_count = phase_len(CLR_CYC);
            end
         end
         CSRAM_WSET: begin
            tmr_load = 1'b1;
            tmr_count = phase_len(WR_CYC);
         end
         CSRAM_WSTB: ;
         CSRAM_WHLD: ;
         CSRAM_RACC: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_count = phase_len(FLT_CYC);
            end
         end
         CSRAM_RFLT: ;
         CSRAM_CLR: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_count = phase_len(REL_CYC);
            end
         end
         CSRAM_CREL: ;
      endcase
      if (state == CSRAM_IDLE && !i_clear_req && i_req_valid && !i_req_write) begin
         tmr_load = 1'b1;
         tmr_count = phase_len(RD_CYC);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= CSRAM_IDLE;
         o_word_address <= '0;
         o_byte_bus_out <= '0;
         o_byte_bus_oe <= 1'b0;
         o_select_low_active_n <= 1'b1;
         o_select_high_power <= 1'b0;
         o_output_enable_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_clear_n <= 1'b1;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end else begin
         o_rd_valid <= 1'b0;
         unique case (state)
            CSRAM_IDLE: begin
               // Power down only between accesses
               o_select_high_power <= !i_power_down;
               if (i_clear_req) begin
                  o_clear_n <= 1'b0;
                  state <= CSRAM_CLR;
               end else if (i_req_valid) begin
                  // Address moves only while the strobe is high; reads drop select on the same edge
                  o_word_address <= i_req_addr;
                  o_select_high_power <= 1'b1;
                  if (i_req_write) begin
                     o_byte_bus_out <= i_req_data;
                     o_byte_bus_oe <= 1'b1;
                     state <= CSRAM_WSET;
                  end else begin
                     o_select_low_active_n <= 1'b0;
                     o_output_enable_n <= 1'b0;
                     state <= CSRAM_RACC;
                  end
               end
            end
            CSRAM_WSET: begin
               // Select and strobe fall together so the memory never drives
               o_select_low_active_n <= 1'b0;
               o_write_strobe_n <= 1'b0;
               state <= CSRAM_WSTB;
            end
            CSRAM_WSTB: begin
               // Long strobe covers both output-enable cases
               if (tmr_done) begin
                  o_write_strobe_n <= 1'b1;
                  o_select_low_active_n <= 1'b1;
                  state <= CSRAM_WHLD;
               end
            end
            CSRAM_WHLD: begin
               // One cycle of data hold after the strobe rises
               o_byte_bus_oe <= 1'b0;
               state <= CSRAM_IDLE;
            end
            CSRAM_RACC: begin
               if (tmr_done) begin
                  o_rd_data <= bus_sync;
                  o_rd_valid <= 1'b1;
                  o_output_enable_n <= 1'b1;
                  o_select_low_active_n <= 1'b1;
                  state <= CSRAM_RFLT;
               end
            end
            CSRAM_RFLT: begin
               // Memory drivers must float before the bus is reused
               if (tmr_done) begin
                  state <= CSRAM_IDLE;
               end
            end
            CSRAM_CLR: begin
               if (tmr_done) begin
                  o_clear_n <= 1'b1;
                  state <= CSRAM_CREL;
               end
            end
            CSRAM_CREL: begin
               if (tmr_done) begin
                  state <= CSRAM_IDLE;
               end
            end
         endcase
      end
   end

   // Helper counters for widths
   logic [CNT_W-1:0] strobe_low_cnt;
   logic [CNT_W-1:0] clear_low_cnt;
   always_ff @(posedge i_clk) begin
      if (i_reset || o_write_strobe_n) begin
         strobe_low_cnt <= '0;
      end else begin
         strobe_low_cnt <= strobe_low_cnt + 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_reset || o_clear_n) begin
         clear_low_cnt <= '0;
      end else begin
         clear_low_cnt <= clear_low_cnt + 1'b1;
      end
   end

   default clocking dc @(posedge i_clk); endclocking
   default disable iff (i_reset);

   clear_alone_a: assert property (!o_clear_n |-> o_write_strobe_n && o_select_low_active_n)
      else $error("clear overlaps an access");
   select_both_a: assert property (!o_output_enable_n |-> !o_select_low_active_n && o_select_high_power)
      else $error("read without full select");
   power_idle_a: assert property ((state == CSRAM_IDLE && i_power_down && !i_req_valid
      && !i_clear_req) |=> !o_select_high_power)
      else $error("power down not taken");
   read_done_a: assert property ($fell(o_output_enable_n) |-> ##[1:40] o_rd_valid)
      else $error("read data not returned");
   write_sel_a: assert property (!o_write_strobe_n |-> !o_select_low_active_n
      && o_select_high_power && o_byte_bus_oe && o_output_enable_n)
      else $error("strobe without select or data");
   // Reads move the address with select falling; the strobe stays high then
   addr_stable_a: assert property ($changed(o_word_address) |->
      (o_write_strobe_n || o_select_low_active_n)
      && ($past(o_write_strobe_n) || $past(o_select_low_active_n)))
      else $error("address moved during access");
   sel_with_strobe_a: assert property ($fell(o_write_strobe_n) |-> $fell(o_select_low_active_n))
      else $error("select before strobe");
   // Counter already holds the full low count on the edge that sees the rise
   strobe_width_a: assert property ($rose(o_write_strobe_n) |->
      strobe_low_cnt == CNT_W'(WR_CYC))
      else $error("strobe width wrong");
   clear_width_a: assert property ($rose(o_clear_n) |-> clear_low_cnt == CNT_W'(CLR_CYC))
      else $error("clear pulse width wrong");
   clear_release_a: assert property ($rose(o_clear_n) |-> o_write_strobe_n [*3])
      else $error("strobe too soon after clear");
   bus_drive_a: assert property (o_byte_bus_oe |-> o_output_enable_n)
      else $error("bus driven against memory");
   data_hold_a: assert property (!o_write_strobe_n |=> $stable(o_byte_bus_out))
      else $error("write data moved under strobe");

   write_seen_c: cover property ($rose(o_write_strobe_n));
   read_seen_c: cover property (o_rd_valid);
   clear_seen_c: cover property ($rose(o_clear_n) ##[1:5] !o_select_low_active_n);
   power_seen_c: cover property ($fell(o_select_high_power));
endmodule

// >>> dv/csram_mem_model.sv
/*
 Behavioural model of the clearable 8K x 8 static memory on the far side.
 Assumes the controller pins are wired directly; this model also resolves the data wire.
*/
module csram_mem_model (
   // Float pattern clock
   input wire logic i_clk,
   // Memory pins
   input wire logic [12:0] i_word_address,
   input wire logic [7:0] i_ctrl_data,
   input wire logic i_ctrl_oe,
   input wire logic i_select_low_active_n,
   input wire logic i_select_high_power,
   input wire logic i_output_enable_n,
   input wire logic i_write_strobe_n,
   input wire logic i_clear_n,
   // Resolved wire and status
   output logic [7:0] o_byte_bus,
   output logic o_mem_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [8192];
   logic sel;
   logic flt = 1'b0;
   assign sel = !i_select_low_active_n && i_select_high_power;
   // Drives only on strobe-high reads, so a write never shows old data
   assign o_mem_drive = sel && i_write_strobe_n && !i_output_enable_n && i_clear_n;
   always @(posedge i_clk) flt <= ~flt;
   // A released wire moves every cycle instead of keeping its last value
   assign o_byte_bus = i_ctrl_oe ? i_ctrl_data :
      (o_mem_drive ? mem[i_word_address] : {4{flt, ~flt}});
   always @(negedge i_clear_n) foreach (mem[i]) mem[i] = 8'h00;
   always @(*) begin
      if (i_clear_n && sel && !i_write_strobe_n) mem[i_word_address] = o_byte_bus;
   end
endmodule

// >>> dv/clearable_async_sram_tb.sv
/*
 Self-checking bench for the memory controller against the memory model.
 Assumes csram_consts.svh on the include path and default controller parameters.
*/
`include "csram_consts.svh"
module clearable_async_sram_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STB_CYC = `CSRAM_CYC(`CSRAM_MAX(`CSRAM_STROBE_WIDTH_MIN_NS,
      `CSRAM_STROBE_TO_FLOAT_NS + `CSRAM_ADDRESS_VALID_TO_WRITE_END_NS));
   localparam int CLR_CYC = `CSRAM_CYC(`CSRAM_MAX(`CSRAM_CLEAR_PULSE_MIN_NS, 2 * `CSRAM_ACCESS_NS));
   localparam int REL_CYC = `CSRAM_CYC(`CSRAM_CLEAR_RELEASE_TO_STROBE_NS);
   logic i_clk = 0, i_reset = 1, req_valid = 0, req_write = 0, clear_req = 0, power_down = 0;
   logic [12:0] req_addr = 0, word_address, prev_addr = 0;
   logic [7:0] req_data = 0, rd_data, bus_out, bus;
   logic req_ready, rd_valid, busy, bus_oe, sel_n, sel_h, oe_n, we_n, clr_n, mem_drive;
   logic act, prev_act = 0;
   int num_errors = 0, checks_done = 0, stb_cnt = 0, clr_cnt = 0, rel_cnt = 100;
   logic [7:0] shadow [8192];
   logic [7:0] exp_q [$];
   logic [12:0] addrs [6];

   csram_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_req_valid(req_valid),
      .i_req_write(req_write), .i_req_addr(req_addr), .i_req_data(req_data),
      .i_clear_req(clear_req), .i_power_down(power_down), .o_req_ready(req_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(busy),
      .o_word_address(word_address), .o_byte_bus_out(bus_out), .o_byte_bus_oe(bus_oe),
      .i_byte_bus_in(bus), .o_select_low_active_n(sel_n), .o_select_high_power(sel_h),
      .o_output_enable_n(oe_n), .o_write_strobe_n(we_n), .o_clear_n(clr_n));
   csram_mem_model mem_u (.i_clk(i_clk), .i_word_address(word_address), .i_ctrl_data(bus_out),
      .i_ctrl_oe(bus_oe), .i_select_low_active_n(sel_n), .i_select_high_power(sel_h),
      .i_output_enable_n(oe_n), .i_write_strobe_n(we_n), .i_clear_n(clr_n),
      .o_byte_bus(bus), .o_mem_drive(mem_drive));

   initial forever #2.5 i_clk = ~i_clk;

   task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_cnt(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic do_req(input logic wr, input logic [12:0] a, input logic [7:0] d);
      @(negedge i_clk);
      req_valid = 1;
      req_write = wr;
      req_addr = a;
      req_data = d;
      while (req_ready !== 1'b1) @(negedge i_clk);
      if (wr) shadow[a] = d;
      else exp_q.push_back(shadow[a]);
      @(negedge i_clk);
      req_valid = 0;
   endtask
   // A write offered with the clear must lose to it
   task automatic do_clear();
      @(negedge i_clk);
      clear_req = 1;
      req_valid = 1;
      req_write = 1;
      req_data = 8'h5a;
      while (busy !== 1'b0) @(negedge i_clk);
      @(negedge i_clk);
      clear_req = 0;
      req_valid = 0;
      foreach (shadow[i]) shadow[i] = 8'h00;
   endtask

   always @(posedge i_clk) begin
      if (!i_reset) begin
         if (rd_valid === 1'b1) cmp_byte("read data", exp_q.size() ? exp_q.pop_front() : 8'hxx, rd_data);
         if (we_n === 1'b0) begin
            if (stb_cnt == 0) cmp_cnt("clear to strobe", 1, 16'(rel_cnt >= REL_CYC));
            stb_cnt++;
         end else if (stb_cnt > 0) begin
            cmp_cnt("strobe width", 16'(STB_CYC), 16'(stb_cnt));
            stb_cnt = 0;
         end
         if (clr_n === 1'b0) begin
            clr_cnt++;
            rel_cnt = 0;
         end else begin
            if (clr_cnt > 0) cmp_cnt("clear width", 16'(CLR_CYC), 16'(clr_cnt));
            clr_cnt = 0;
            if (rel_cnt < 100) rel_cnt++;
         end
         act = !we_n && !sel_n && sel_h;
         if (word_address !== prev_addr) cmp_cnt("address move", 0, {15'h0, prev_act | act});
         prev_addr = word_address;
         prev_act = act;
         if (bus_oe === 1'b1) cmp_cnt("bus contention", 0, {15'h0, mem_drive});
      end
   end

   initial begin
      repeat (6000) @(posedge i_clk);
      num_errors++;
      complete_run();
   end

   initial begin
      void'($urandom(41));
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      i_reset = 0;
      cmp_cnt("idle pins", 16'h3c, {10'h0, clr_n, we_n, oe_n, sel_n, sel_h, bus_oe});
      for (int i = 0; i < 6; i++) begin
         addrs[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom);
         do_req(1, addrs[i], 8'($urandom));
      end
      for (int i = 0; i < 6; i++) do_req(0, addrs[5 - i], 8'h00);
      do_clear();
      for (int i = 0; i < 6; i++) do_req(0, addrs[i], 8'h00);
      do_req(1, addrs[2], 8'hc3);
      @(negedge i_clk);
      power_down = 1;
      while (busy !== 1'b0) @(negedge i_clk);
      repeat (3) @(negedge i_clk);
      cmp_cnt("power down select", 0, {15'h0, sel_h});
      do_req(0, addrs[2], 8'h00);
      power_down = 0;
      repeat (30) @(negedge i_clk);
      cmp_cnt("reads left", 0, 16'(exp_q.size()));
      complete_run();
   end
endmodule
